/* hdl/twi_pkg.sv */
package twi_pkg;

    localparam int CLK_FREQ_KHZ = 100000;
    localparam int BUS_STD_KHZ = 100;
    localparam int BUS_FAST_KHZ = 400;
    // Quarter bit periods, rounded down so the bus never runs too slow
    localparam logic [8:0] QTR_STD_CYC = 9'(CLK_FREQ_KHZ / (4 * BUS_STD_KHZ));
    localparam logic [8:0] QTR_FAST_CYC = 9'(CLK_FREQ_KHZ / (4 * BUS_FAST_KHZ));

    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] TAR_OFS = 8'h04;
    localparam logic [7:0] OWN_OFS = 8'h08;
    localparam logic [7:0] DATA_OFS = 8'h0C;
    localparam logic [7:0] HOLD_OFS = 8'h10;
    localparam logic [7:0] STAT_OFS = 8'h14;
    localparam logic [7:0] RAW_OFS = 8'h18;
    localparam logic [7:0] MASK_OFS = 8'h1C;
    localparam logic [7:0] INTR_OFS = 8'h20;
    localparam logic [7:0] CLR_OFS = 8'h24;

    localparam logic [3:0] CTRL_RST = 4'h4;
    localparam logic [9:0] TAR_RST = 10'h000;
    localparam logic [9:0] OWN_ADDR_RST = 10'h055;
    localparam logic [7:0] HOLD_RST = 8'h01;
    localparam logic [4:0] TEN_BIT_MARK = 5'h1E;
    localparam int CMD_BIT = 8;

    localparam int INT_W = 7;
    localparam int INT_ABORT = 0;
    localparam int INT_START = 1;
    localparam int INT_STOP = 2;
    localparam int INT_RX_FULL = 3;
    localparam int INT_TX_EMPTY = 4;
    localparam int INT_TX_OVER = 5;
    localparam int INT_RX_UNDER = 6;

    typedef struct packed {
        logic addr10;
        logic restart_en;
        logic fast;
        logic enable;
    } ctrl_s;

    typedef struct packed {
        logic cmd;
        logic [7:0] data;
    } tx_entry_s;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_START = 3'h1,
        ST_BIT = 3'h2,
        ST_NEXT = 3'h3,
        ST_STOP = 3'h4
    } state_e;

    typedef enum logic [1:0] {
        PH_ADDR1 = 2'h0,
        PH_ADDR2 = 2'h1,
        PH_DATA = 2'h2
    } phase_e;

endpackage

/* hdl/twi_master.sv */
// Overview of operation
// - Standard 100 kbit/s and fast 400 kbit/s bus speeds.
// - Separate 32-entry transmit and receive FIFOs with readable levels.
// - Both 7-bit and 10-bit target addressing, also in combined transfers.
// - Own address setting resets to 0x055.
// - Programmable data hold time after each clock fall that ends a bit.
// - START pulls data low while clock is high; bus becomes busy.
// - STOP releases data while clock is high; bus becomes idle.
// - Acts only as bus master, generating the clock.
// - Address and direction follow START; the slave acknowledges.
// - The receiving party drives each acknowledge bit.
// - Reads acknowledge every byte but the last, then STOP or restart; nack comes only when the read is the last FIFO entry.
// - Data changes only while clock is low, except start and stop.
// - Both lines are open drain: pull low or release.
// - A FIFO entry while idle starts a transaction with START.
// - An empty transmit FIFO after a transfer gives STOP.
// - With restart enabled, a direction change uses a repeated START.
// - One address width for a whole combined sequence.
// - Clock held low while no data can be taken; released on disable.
// - Sampled lines detect start, stop and arbitration loss; clock sync.
// - Raw and masked status flags, settable and clearable, pollable.
// - Tolerates slave clock stretching at bit and byte level.
// - 7-bit first byte holds address in 7:1, direction in bit 0.
// - 10-bit first byte 11110, address 9:8, direction; then low byte.
// - A missing acknowledge aborts the transfer with STOP.
// - Input clock divided to 100 kHz or 400 kHz by speed setting.
`timescale 1ns/10ps
`default_nettype none
module twi_master import twi_pkg::*; #(
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_LVL = (AW+1)'(DEPTH);

    function automatic logic [AW:0] lvl(input logic [AW:0] wp, input logic [AW:0] rp);
        lvl = wp - rp;
    endfunction

    function automatic logic hit(input logic [7:0] a);
        hit = (a <= CLR_OFS) && (a[1:0] == 2'b00);
    endfunction

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    ctrl_s ctrl_reg;
    logic [9:0] tar_reg, own_addr_reg;
    logic [7:0] hold_reg, hold_cnt_reg;
    logic [INT_W-1:0] raw_reg, mask_reg, ev;
    logic [31:0] rdata_next;
    logic scl_m_reg, scl_s, sda_m_reg, sda_s, sda_d_reg, scl_d_reg;
    logic bus_busy_reg;
    state_e state_reg;
    phase_e phase_reg;
    logic [1:0] q_reg;
    logic [3:0] bit_reg;
    logic [8:0] sh_reg, rx_sh_reg;
    logic dir_reg, rd_reg, ten_reg, active_reg, scl_oe_reg, sda_oe_reg;
    logic abort_reg, tx_pop_reg, rx_push_reg;
    logic [8:0] div_reg;
    logic tick, scl_wait, arb, rx_full_n;
    tx_entry_s tx_mem [DEPTH];
    logic [7:0] rx_mem [DEPTH];
    logic [AW:0] tx_wp, tx_rp, rx_wp, rx_rp, tx_lvl, rx_lvl;
    tx_entry_s tx_head;
    logic acc, wr, rd, tx_push, rx_pop;

    // APB slave: zero wait states, error on unmapped words
    assign acc = psel & penable;
    assign wr = acc & pwrite & hit(paddr);
    assign rd = acc & ~pwrite & hit(paddr);
    assign pready = 1'b1;
    assign pslverr = acc & ~hit(paddr);
    assign tx_push = wr && paddr == DATA_OFS && tx_lvl != FULL_LVL;
    assign rx_pop = rd && paddr == DATA_OFS && rx_lvl != '0;

    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe = scl_oe_reg;
    assign sda_oe = sda_oe_reg;

    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_reg <= CTRL_RST;
            tar_reg <= TAR_RST;
            own_addr_reg <= OWN_ADDR_RST;
            hold_reg <= HOLD_RST;
            mask_reg <= '0;
        end else if (wr) begin
            case (paddr)
                CTRL_OFS: ctrl_reg <= pwdata[3:0];
                TAR_OFS: tar_reg <= pwdata[9:0];
                OWN_OFS: own_addr_reg <= pwdata[9:0];
                HOLD_OFS: hold_reg <= pwdata[7:0];
                MASK_OFS: mask_reg <= pwdata[INT_W-1:0];
                default: ;
            endcase
        end
    end

    own_addr_rst_a: assert property ($fell(reset) |-> own_addr_reg == OWN_ADDR_RST)
        else $error("own address not at reset value");

    // raw flags, set wins over clear
    always_comb begin
        ev = '0;
        ev[INT_ABORT] = abort_reg;
        ev[INT_START] = scl_s & sda_d_reg & ~sda_s;
        ev[INT_STOP] = scl_s & ~sda_d_reg & sda_s;
        ev[INT_RX_FULL] = rx_lvl == FULL_LVL;
        ev[INT_TX_EMPTY] = tx_lvl == '0;
        ev[INT_TX_OVER] = wr && paddr == DATA_OFS && tx_lvl == FULL_LVL;
        ev[INT_RX_UNDER] = rd && paddr == DATA_OFS && rx_lvl == '0;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            raw_reg <= '0;
        end else begin
            raw_reg <= (raw_reg & ~((wr && paddr == CLR_OFS) ? pwdata[INT_W-1:0] : '0)) | ev;
        end
    end

    always_comb begin
        rdata_next = '0;
        case (paddr)
            CTRL_OFS: rdata_next = 32'(ctrl_reg);
            TAR_OFS: rdata_next = 32'(tar_reg);
            OWN_OFS: rdata_next = 32'(own_addr_reg);
            DATA_OFS: rdata_next = 32'(rx_mem[rx_rp[AW-1:0]]);
            HOLD_OFS: rdata_next = 32'(hold_reg);
            STAT_OFS: rdata_next = 32'({rx_lvl, tx_lvl, bus_busy_reg, active_reg});
            RAW_OFS: rdata_next = 32'(raw_reg);
            MASK_OFS: rdata_next = 32'(mask_reg);
            INTR_OFS: rdata_next = 32'(raw_reg & mask_reg);
            default: rdata_next = '0;
        endcase
    end

    // Captured in the setup phase so the access phase sees a flop
    always_ff @(posedge clk) begin
        if (reset) begin
            prdata <= '0;
        end else if (psel & ~penable & ~pwrite) begin
            prdata <= rdata_next;
        end
    end

    // entry is byte plus command bit
    assign tx_lvl = lvl(tx_wp, tx_rp);
    assign tx_head = tx_mem[tx_rp[AW-1:0]];
    always_ff @(posedge clk) begin
        if (tx_push) begin
            tx_mem[tx_wp[AW-1:0]] <= tx_entry_s'(pwdata[CMD_BIT:0]);
        end
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            tx_wp <= '0;
            tx_rp <= '0;
        end else begin
            if (tx_push) begin
                tx_wp <= tx_wp + 1'b1;
            end
            if (abort_reg) begin
                tx_rp <= tx_wp;
            end else if (tx_pop_reg) begin
                tx_rp <= tx_rp + 1'b1;
            end
        end
    end

    abort_flush_a: assert property (abort_reg |=> tx_rp == $past(tx_wp) && raw_reg[INT_ABORT])
        else $error("abort did not flush and flag");

    assign rx_lvl = lvl(rx_wp, rx_rp);
    assign rx_full_n = rx_lvl == FULL_LVL || (rx_push_reg && rx_lvl == FULL_LVL - 1'b1);
    always_ff @(posedge clk) begin
        if (rx_push_reg) begin
            rx_mem[rx_wp[AW-1:0]] <= rx_sh_reg[8:1];
        end
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            rx_wp <= '0;
            rx_rp <= '0;
        end else begin
            if (rx_push_reg) begin
                rx_wp <= rx_wp + 1'b1;
            end
            if (rx_pop) begin
                rx_rp <= rx_rp + 1'b1;
            end
        end
    end

    // line synchronisers and bus event filter
    always_ff @(posedge clk) begin
        if (reset) begin
            scl_m_reg <= 1'b1;
            scl_s <= 1'b1;
            sda_m_reg <= 1'b1;
            sda_s <= 1'b1;
            sda_d_reg <= 1'b1;
            scl_d_reg <= 1'b1;
            bus_busy_reg <= 1'b0;
        end else begin
            scl_m_reg <= scl_in;
            scl_s <= scl_m_reg;
            sda_m_reg <= sda_in;
            sda_s <= sda_m_reg;
            sda_d_reg <= sda_s;
            scl_d_reg <= scl_s;
            if (ev[INT_START]) begin
                bus_busy_reg <= 1'b1;
            end else if (ev[INT_STOP]) begin
                bus_busy_reg <= 1'b0;
            end
        end
    end

    // released clock held low by a slave freezes the divider
    assign scl_wait = state_reg != ST_IDLE && !scl_oe_reg && !(scl_s && scl_d_reg);

    assign tick = !scl_wait && div_reg == '0;
    always_ff @(posedge clk) begin
        if (reset || state_reg == ST_IDLE) begin
            div_reg <= '0;
        end else if (!scl_wait) begin
            div_reg <= (div_reg == '0) ? (ctrl_reg.fast ? QTR_FAST_CYC : QTR_STD_CYC) - 1'b1
                                       : div_reg - 1'b1;
        end
    end

    stretch_hold_a: assert property (scl_wait |=> $stable(q_reg) && $stable(div_reg))
        else $error("bit timing advanced during clock stretch");

    // hold counter restarts at each falling clock that ends a bit, not at the fall after START
    always_ff @(posedge clk) begin
        if (reset || (state_reg == ST_BIT && tick && q_reg == 2'd3)) begin
            hold_cnt_reg <= '0;
        end else if (hold_cnt_reg != 8'hFF) begin
            hold_cnt_reg <= hold_cnt_reg + 1'b1;
        end
    end

    // released data read low while we send means lost arbitration
    assign arb = sh_reg[8] && !sda_s && (rd_reg ? bit_reg == 4'd8 : bit_reg != 4'd8);

    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= ST_IDLE;
            phase_reg <= PH_ADDR1;
            q_reg <= '0;
            bit_reg <= '0;
            sh_reg <= '1;
            rx_sh_reg <= '0;
            dir_reg <= 1'b0;
            rd_reg <= 1'b0;
            ten_reg <= 1'b0;
            active_reg <= 1'b0;
            scl_oe_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
            abort_reg <= 1'b0;
            tx_pop_reg <= 1'b0;
            rx_push_reg <= 1'b0;
        end else begin
            abort_reg <= 1'b0;
            tx_pop_reg <= 1'b0;
            rx_push_reg <= 1'b0;
            if (!ctrl_reg.enable) begin
                state_reg <= ST_IDLE;
                scl_oe_reg <= 1'b0;
                sda_oe_reg <= 1'b0;
                active_reg <= 1'b0;
            end else begin
                case (state_reg)
                    ST_IDLE: begin
                        // queued entry starts a transaction
                        // Abort flush lands one cycle late, so its entries must not start
                        if (tx_lvl != '0 && !abort_reg) begin
                            state_reg <= ST_START;
                            q_reg <= '0;
                            dir_reg <= tx_head.cmd;
                            ten_reg <= ctrl_reg.addr10;
                            phase_reg <= PH_ADDR1;
                            active_reg <= 1'b1;
                        end
                    end
                    ST_START: begin
                        if (tick) begin
                            q_reg <= q_reg + 1'b1;
                            case (q_reg)
                                2'd0: scl_oe_reg <= 1'b0;
                                2'd1: sda_oe_reg <= 1'b1;
                                2'd2: scl_oe_reg <= 1'b1;
                                default: begin
                                    state_reg <= ST_BIT;
                                    bit_reg <= '0;
                                    rd_reg <= 1'b0;
                                    sh_reg <= ten_reg ? {TEN_BIT_MARK, tar_reg[9:8], dir_reg, 1'b1}
                                                      : {tar_reg[6:0], dir_reg, 1'b1};
                                end
                            endcase
                        end else if (q_reg == 2'd0) begin
                            sda_oe_reg <= 1'b0;
                        end
                    end
                    ST_BIT: begin
                        if (tick) begin
                            q_reg <= q_reg + 1'b1;
                            case (q_reg)
                                2'd1: scl_oe_reg <= 1'b0;
                                2'd2: begin
                                    rx_sh_reg <= {rx_sh_reg[7:0], sda_s};
                                    if (arb) begin
                                        abort_reg <= 1'b1;
                                        state_reg <= ST_IDLE;
                                        sda_oe_reg <= 1'b0;
                                        active_reg <= 1'b0;
                                    end
                                end
                                2'd3: begin
                                    scl_oe_reg <= 1'b1;
                                    sh_reg <= {sh_reg[7:0], 1'b1};
                                    bit_reg <= bit_reg + 1'b1;
                                    if (bit_reg == 4'd8) begin
                                        if (!rd_reg && rx_sh_reg[0]) begin
                                            abort_reg <= 1'b1;
                                            state_reg <= ST_STOP;
                                        end else if (phase_reg == PH_ADDR1 && ten_reg) begin
                                            phase_reg <= PH_ADDR2;
                                            sh_reg <= {tar_reg[7:0], 1'b1};
                                            bit_reg <= '0;
                                        end else begin
                                            rx_push_reg <= rd_reg;
                                            phase_reg <= PH_DATA;
                                            state_reg <= ST_NEXT;
                                        end
                                    end
                                end
                                default: ;
                            endcase
                        end else if (q_reg == 2'd1 || (q_reg == 2'd0 && hold_cnt_reg >= hold_reg)) begin
                            // data moves only with clock low
                            sda_oe_reg <= ~sh_reg[8];
                        end
                    end
                    ST_NEXT: begin
                        q_reg <= '0;
                        if (tx_lvl == '0) begin
                            state_reg <= ST_STOP;
                        end else if (tx_head.cmd != dir_reg) begin
                            if (ctrl_reg.restart_en) begin
                                state_reg <= ST_START;
                                dir_reg <= tx_head.cmd;
                                phase_reg <= PH_ADDR1;
                            end else begin
                                state_reg <= ST_STOP;
                            end
                        end else if (!(tx_head.cmd && rx_full_n)) begin
                            // clock stays low until room exists
                            tx_pop_reg <= 1'b1;
                            rd_reg <= tx_head.cmd;
                            bit_reg <= '0;
                            state_reg <= ST_BIT;
                            sh_reg <= tx_head.cmd ? {8'hFF, tx_lvl == 1}
                                                  : {tx_head.data, 1'b1};
                        end
                    end
                    ST_STOP: begin
                        if (tick) begin
                            q_reg <= q_reg + 1'b1;
                            case (q_reg)
                                2'd0: scl_oe_reg <= 1'b0;
                                2'd1: sda_oe_reg <= 1'b0;
                                2'd3: begin
                                    state_reg <= ST_IDLE;
                                    active_reg <= 1'b0;
                                end
                                default: ;
                            endcase
                        end else if (q_reg == 2'd0) begin
                            sda_oe_reg <= 1'b1;
                        end
                    end
                    default: state_reg <= ST_IDLE;
                endcase
            end
        end
    end

    sequence start_edge;
        state_reg == ST_START && $rose(sda_oe_reg);
    endsequence

    sequence stop_edge;
        state_reg == ST_STOP && $fell(sda_oe_reg);
    endsequence

    start_cond_a: assert property (start_edge |-> !scl_oe_reg)
        else $error("start formed with clock low");

    stop_cond_a: assert property (stop_edge |-> !scl_oe_reg ##1 state_reg == ST_STOP)
        else $error("stop formed with clock low");

    sda_steady_a: assert property (state_reg == ST_BIT && $changed(sda_oe_reg) && !$past(arb)
                                   |-> scl_oe_reg)
        else $error("data moved while clock high");

    idle_start_a: assert property (state_reg == ST_IDLE && ctrl_reg.enable && tx_lvl != '0
                                   && !abort_reg
                                   |=> state_reg == ST_START ##1 !sda_oe_reg)
        else $error("queued entry did not start");

    empty_stop_a: assert property (ctrl_reg.enable && state_reg == ST_NEXT && tx_lvl == '0
                                   |=> state_reg == ST_STOP)
        else $error("empty FIFO did not stop");

    // nack leads to stop and abort
    nack_stop_a: assert property (ctrl_reg.enable && state_reg == ST_BIT && tick && q_reg == 2'd3
                                  && bit_reg == 4'd8 && !rd_reg && rx_sh_reg[0]
                                  |=> state_reg == ST_STOP && abort_reg)
        else $error("nack did not abort with stop");

    // last read byte answered with nack
    read_last_a: assert property (tx_pop_reg && rd_reg
                                  |-> sh_reg[0] == ($past(tx_lvl) == 1))
        else $error("read acknowledge wrong for position");

endmodule
`default_nettype wire

/* verif/twi_slave_model.sv */
`timescale 1ns/10ps
`default_nettype none
module twi_slave_model #(parameter logic [6:0] ADDR = 7'h3A, parameter logic [7:0] RD = 8'h5A) (
    input wire logic scl,
    input wire logic sda,
    output logic pull,
    output logic [7:0] got
);
    logic [7:0] sh = 8'h00;
    logic rd = 1'h0, first = 1'h0;
    int cnt = 0;
    initial pull = 1'h0;
    always @(negedge sda) if (scl === 1'h1) begin cnt = 0; first = 1'h1; rd = 1'h0; end
    always @(posedge scl) begin sh = {sh[6:0], sda}; cnt++; end
    always @(negedge scl) begin
        if (cnt == 8) begin
            if (!first && !rd) got = sh;
            pull = first ? sh[7:1] === ADDR : !rd;
            if (first) rd = sh[0] & (sh[7:1] === ADDR);
            first = 1'h0;
        end else if (cnt == 9) begin
            cnt = 0;
            // Master nack releases the line for stop
            rd = rd & ~sh[0];
            pull = rd & ~RD[7];
        end else pull = rd & ~RD[7 - cnt];
    end
endmodule
`default_nettype wire

/* verif/two_wire_bus_master_controller_bench.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
    $display("unexpected %s expected %0h seen %0h", n, e, g); end end
module two_wire_bus_master_controller_bench import twi_pkg::*;;
    logic clk = 1'h0, reset = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0] paddr = 8'h00, got;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, scl_oe, sda_oe, scl_out, sda_out, pull, err;
    int n_errors = 0, checks = 0, n_start = 0, n_stop = 0;
    int n_edge = 0;
    realtime t_edge = 0.0, scl_per = 0.0;
    wire logic scl = ~scl_oe;
    wire logic sda = ~(sda_oe | pull);
    always #5 clk = ~clk;
    twi_master u_twi_master (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .scl_in(scl), .scl_out, .scl_oe, .sda_in(sda), .sda_out, .sda_oe);
    twi_slave_model u_twi_slave_model (.scl, .sda, .pull, .got);
    always @(negedge sda) begin
        if (scl === 1'h1) begin
            n_start++;
            n_edge = 0;
        end
    end
    // Bit period from the first two clock pulses after each start
    always @(posedge scl) begin
        n_edge++;
        if (n_edge == 2) scl_per = $realtime - t_edge;
        t_edge = $realtime;
    end
    always @(posedge sda) if (scl === 1'h1) n_stop++;
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        q = prdata; err = pslverr;
        psel <= 1'h0; penable <= 1'h0;
        @(posedge clk);
    endtask
    task automatic run(input logic [31:0] d0, input logic [31:0] d1);
        n_start = 0; n_stop = 0;
        bus(1'h1, DATA_OFS, d0);
        bus(1'h1, DATA_OFS, d1);
        for (int i = 0; i < 20000; i++) begin
            bus(1'h0, STAT_OFS, 32'h0);
            if (q[0] === 1'h0 && q[7:2] === 6'h00) break;
        end
        `CHK("transfer finished", 1'h0, q[0] | (|q[7:2]))
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic t_reset();
        bus(1'h0, OWN_OFS, 32'h0);
        `CHK("own address", 32'h55, q)
        `CHK("line drive", 4'h0, {scl_out, sda_out, scl_oe, sda_oe})
        bus(1'h1, 8'h3C, 32'h1);
        `CHK("unmapped error", 1'h1, err)
        $display("reset test done");
    endtask
    task automatic t_combo();
        bus(1'h1, TAR_OFS, 32'h3A);
        bus(1'h1, CTRL_OFS, 32'h7);
        // Write then read, so the direction change needs a repeated start
        run(32'hC3, 32'h100);
        `CHK("starts", 2, n_start)
        `CHK("stops", 1, n_stop)
        `CHK("fast bit period", 1'h1, scl_per >= 2500.0 && scl_per < 10000.0)
        `CHK("written byte", 8'hC3, got)
        bus(1'h0, DATA_OFS, 32'h0);
        `CHK("read byte", 32'h5A, q)
        $display("combined test done");
    endtask
    task automatic t_nack();
        bus(1'h1, TAR_OFS, 32'h11);
        run(32'hC3, 32'h3C);
        `CHK("stops", 1, n_stop)
        bus(1'h0, RAW_OFS, 32'h0);
        `CHK("abort flag", 1'h1, q[0])
        bus(1'h0, STAT_OFS, 32'h0);
        `CHK("tx level", 6'h00, q[7:2])
        $display("nack test done");
    endtask
    task automatic t_speed();
        bus(1'h1, TAR_OFS, 32'h3A);
        bus(1'h1, CTRL_OFS, 32'h5);
        // Two writes in one direction need a single start
        run(32'h96, 32'h69);
        `CHK("starts", 1, n_start)
        `CHK("stops", 1, n_stop)
        `CHK("last written byte", 8'h69, got)
        `CHK("std bit period", 1'h1, scl_per >= 10000.0 && scl_per < 20000.0)
        $display("speed test done");
    endtask
    initial begin
        repeat (3) @(posedge clk);
        reset <= 1'h0;
        @(posedge clk);
        t_reset();
        t_combo();
        t_nack();
        t_speed();
        print_verdict();
    end
    // Whole run needs under half of this
    initial #1000000 begin n_errors++; print_verdict(); end
endmodule
`default_nettype wire
